// ---- hw/svf_map.svh ----
// Constants for the scan video frame multiplexer: rates, framing, layout.
// Assumes a 250 MHz system clock and one includer per compilation unit.
`ifndef SVF_MAP_SVH
`define SVF_MAP_SVH
`define SVF_CLK_KHZ 19'd250000
`define SVF_RATE1_KBPS 19'd28000
`define SVF_RATE2_KBPS 19'd14000
`define SVF_PREAMBLE_US 2000
`define SVF_US_PER_MS 1000
`define SVF_SYNC_BITS 56
`define SVF_SYNC_LAST 17'd55
`define SVF_ID_BITS 12
`define SVF_LINE_SYNC 44'hf9a_42b6_e3c5
`define SVF_BARKER 6'h3a
`define SVF_WORDS 6'd36
`define SVF_POS_FIRST 6'd1
`define SVF_POS_SYNC_A 6'd1
`define SVF_POS_SYNC_B 6'd19
`define SVF_POS_SKIP_A 6'd6
`define SVF_POS_SKIP_B 6'd9
`define SVF_POS_TH0 6'd2
`define SVF_POS_TH1 6'd11
`define SVF_POS_TH2 6'd20
`define SVF_POS_TH3 6'd29
`define SVF_VIS_BITS 4'd6
`define SVF_TH_BITS 4'd8
`define SVF_VIS_STEP1 3'd1
`define SVF_VIS_STEP2 3'd2
`define SVF_FRAMES_PER_LINE 4
`endif

// ---- hw/svf_pkg.sv ----
// Types for the scan video frame multiplexer.
// Assumes the map header supplies all numeric constants.
package svf_pkg;
  typedef enum logic [3:0] {
    svf_st_idle = 4'h1,
    svf_st_pre = 4'h2,
    svf_st_sync = 4'h4,
    svf_st_video = 4'h8
  } svf_state_type;
  typedef enum logic [1:0] {
    svf_kind_vis = 2'h0,
    svf_kind_th = 2'h1,
    svf_kind_sync = 2'h2,
    svf_kind_isync = 2'h3
  } svf_kind_type;
endpackage : svf_pkg

// ---- hw/svf_mux.sv ----
// Scan video frame multiplexer: frames converter codes into a serial line.
// Assumes converter codes are on the clk domain; mode, start, ID are pins.
`include "svf_map.svh"
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Sample all ten channels in fixed order; mode two steps vis_chan through the even visible channels only
// [R2] Insert twelve-bit line ID once per scan
// [R3] One of two ground-commanded modes active
// [R4] Send 2 ms alternating preamble first
// [R5] Then one 56-bit sync and ID word
// [R6] Video: six-bit visible, eight-bit thermal words
// [R7] Mode two drops words six through nine
// [R8] Visible codes are six-bit companded values
// [R9] Thermal codes are eight-bit linear values
// [R10] Mode two carries four paired visible channels
// [R11] Frame holds four eight-bit, thirty-two six-bit
// [R12] Ground splits stream at 14/7 Mb/s
// [R13] 36 words, Barker at 1, inverse 19
// [R14] Differentially encode the serial output
// [R15] Mode change waits for next line frame
// [R16] Data words keep fixed position order
module svf_mux #(
  parameter int PREAMBLE_US = `SVF_PREAMBLE_US,
  parameter int FRAMES_PER_LINE = `SVF_FRAMES_PER_LINE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins from command subsystem and radiometer
  input wire logic mode_cmd,
  input wire logic line_start,
  input wire logic [11:0] line_id,
  // Converter results, clk domain
  input wire logic [47:0] vis_code,
  input wire logic [15:0] thermal_code,
  // Channel sequencing to the analog side
  output logic [2:0] vis_chan,
  output logic thermal_chan,
  // Serial stream to the modulator, line busy and active mode
  output logic ser_data,
  output logic ser_strobe,
  output logic line_busy,
  output logic mode_active
);
  localparam int PRE1 = PREAMBLE_US * `SVF_RATE1_KBPS / `SVF_US_PER_MS;
  localparam int PRE2 = PREAMBLE_US * `SVF_RATE2_KBPS / `SVF_US_PER_MS;
  if (PRE2 < 1 || PRE1 > 131072 || FRAMES_PER_LINE < 1 ||
      FRAMES_PER_LINE > 255)
  begin : g_bad_param
    $error("svf_mux: preamble or frame count out of range");
  end

  logic [13:0] in_s1;
  logic [13:0] in_s2;
  logic [13:0] in_s3;
  logic [13:0] in_filt;
  logic start_prev;
  logic start_evt;
  svf_pkg::svf_state_type state_reg;
  logic mode_reg;
  logic [18:0] acc_reg;
  logic [18:0] acc_sum;
  logic [18:0] rate;
  logic tick_reg;
  logic [16:0] cnt_reg;
  logic [16:0] pre_last;
  logic alt_reg;
  logic [55:0] sync_sr;
  logic [7:0] word_reg;
  logic [3:0] len_reg;
  svf_pkg::svf_kind_type kind_reg;
  logic [5:0] pos_reg;
  logic [5:0] pos_nxt;
  logic [5:0] load_pos;
  svf_pkg::svf_kind_type load_kind;
  logic [7:0] frame_reg;
  logic [2:0] vis_idx;
  logic th_idx;
  logic raw_bit;
  logic word_end;
  logic ser_data_reg;
  logic ser_strobe_reg;
  logic busy_reg;

  function automatic svf_pkg::svf_kind_type word_kind(input logic [5:0] p);
    if (p == `SVF_POS_SYNC_A)
      word_kind = svf_pkg::svf_kind_sync;
    else if (p == `SVF_POS_SYNC_B)
      word_kind = svf_pkg::svf_kind_isync;
    else if (p == `SVF_POS_TH0 || p == `SVF_POS_TH1 ||
             p == `SVF_POS_TH2 || p == `SVF_POS_TH3)
      word_kind = svf_pkg::svf_kind_th;
    else
      word_kind = svf_pkg::svf_kind_vis;
  endfunction : word_kind

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_s1 <= 14'h0000;
      in_s2 <= 14'h0000;
      in_s3 <= 14'h0000;
      in_filt <= 14'h0000;
      start_prev <= 1'b0;
    end
    else
    begin
      in_s1 <= {mode_cmd, line_start, line_id};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_filt <= (in_s2 & ~(in_s2 ^ in_s3)) | (in_filt & (in_s2 ^ in_s3));
      start_prev <= in_filt[12];
    end
  end
  assign start_evt = in_filt[12] & ~start_prev;

  // Bit rate from a phase accumulator; 250 MHz is no multiple of 28 Mb/s
  assign rate = mode_reg ? `SVF_RATE2_KBPS : `SVF_RATE1_KBPS; // [R12]
  assign acc_sum = acc_reg + rate;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_reg <= 19'h00000;
      tick_reg <= 1'b0;
    end
    else if (state_reg == svf_pkg::svf_st_idle)
    begin
      acc_reg <= 19'h00000;
      tick_reg <= 1'b0;
    end
    else if (acc_sum >= `SVF_CLK_KHZ)
    begin
      acc_reg <= acc_sum - `SVF_CLK_KHZ;
      tick_reg <= 1'b1;
    end
    else
    begin
      acc_reg <= acc_sum;
      tick_reg <= 1'b0;
    end
  end

  assign pre_last = mode_reg ? 17'(PRE2 - 1) : 17'(PRE1 - 1); // [R4]
  assign word_end = tick_reg && (cnt_reg == 17'(len_reg - 4'd1));

  // Next word position; mode two jumps over the deleted block
  always_comb
  begin
    pos_nxt = (pos_reg == `SVF_WORDS) ? `SVF_POS_FIRST : pos_reg + 6'd1;
    if (mode_reg && pos_nxt == `SVF_POS_SKIP_A)
      pos_nxt = `SVF_POS_SKIP_B + 6'd1; // [R7]
    load_pos = (state_reg == svf_pkg::svf_st_sync) ? `SVF_POS_FIRST : pos_nxt;
    load_kind = word_kind(load_pos); // [R13] [R16]
  end

  // Frame sequencer; mode is latched only between lines
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= svf_pkg::svf_st_idle;
      mode_reg <= 1'b0;
      cnt_reg <= 17'h00000;
      alt_reg <= 1'b1;
      pos_reg <= `SVF_POS_FIRST;
      frame_reg <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        svf_pkg::svf_st_idle:
        begin
          if (start_evt)
          begin
            mode_reg <= in_filt[13]; // [R3] [R15]
            state_reg <= svf_pkg::svf_st_pre;
            cnt_reg <= 17'h00000;
            alt_reg <= 1'b1;
            busy_reg <= 1'b1;
          end
        end
        svf_pkg::svf_st_pre:
        begin
          if (tick_reg)
          begin
            alt_reg <= ~alt_reg; // [R4]
            if (cnt_reg == pre_last)
            begin
              state_reg <= svf_pkg::svf_st_sync; // [R5]
              cnt_reg <= 17'h00000;
            end
            else
              cnt_reg <= cnt_reg + 17'h00001;
          end
        end
        svf_pkg::svf_st_sync:
        begin
          if (tick_reg)
          begin
            if (cnt_reg == `SVF_SYNC_LAST)
            begin
              state_reg <= svf_pkg::svf_st_video; // [R6]
              cnt_reg <= 17'h00000;
              pos_reg <= `SVF_POS_FIRST;
              frame_reg <= 8'h00;
            end
            else
              cnt_reg <= cnt_reg + 17'h00001; // [R5]
          end
        end
        svf_pkg::svf_st_video:
        begin
          if (word_end)
          begin
            cnt_reg <= 17'h00000;
            pos_reg <= load_pos; // [R13]
            if (pos_reg == `SVF_WORDS)
            begin
              frame_reg <= frame_reg + 8'h01;
              if (frame_reg == 8'(FRAMES_PER_LINE - 1))
              begin
                state_reg <= svf_pkg::svf_st_idle;
                busy_reg <= 1'b0;
              end
            end
          end
          else if (tick_reg)
            cnt_reg <= cnt_reg + 17'h00001;
        end
      endcase
    end
  end

  // Sync and ID shifter, loaded as the line starts
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sync_sr <= 56'h0;
    else if (state_reg == svf_pkg::svf_st_idle && start_evt)
      sync_sr <= {`SVF_LINE_SYNC, in_filt[11:0]}; // [R2] [R5]
    else if (state_reg == svf_pkg::svf_st_sync && tick_reg)
      sync_sr <= {sync_sr[54:0], 1'b0};
  end

  // Word shifter, left aligned; channel order restarts every line
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_reg <= 8'h00;
      len_reg <= `SVF_VIS_BITS;
      kind_reg <= svf_pkg::svf_kind_sync;
      vis_idx <= 3'h0;
      th_idx <= 1'b0;
    end
    else if (state_reg == svf_pkg::svf_st_idle)
    begin
      vis_idx <= 3'h0; // [R16]
      th_idx <= 1'b0;
    end
    else if ((state_reg == svf_pkg::svf_st_sync && tick_reg &&
              cnt_reg == `SVF_SYNC_LAST) ||
             (state_reg == svf_pkg::svf_st_video && word_end))
    begin
      kind_reg <= load_kind;
      unique case (load_kind)
        svf_pkg::svf_kind_sync:
        begin
          word_reg <= {`SVF_BARKER, 2'b00}; // [R13]
          len_reg <= `SVF_VIS_BITS;
        end
        svf_pkg::svf_kind_isync:
        begin
          word_reg <= {~`SVF_BARKER, 2'b00}; // [R13]
          len_reg <= `SVF_VIS_BITS;
        end
        svf_pkg::svf_kind_th:
        begin
          word_reg <= thermal_code[th_idx*8 +: 8]; // [R9] [R11]
          len_reg <= `SVF_TH_BITS; // [R6]
          th_idx <= ~th_idx; // [R1]
        end
        svf_pkg::svf_kind_vis:
        begin
          word_reg <= {vis_code[vis_idx*6 +: 6], 2'b00}; // [R8] [R11]
          len_reg <= `SVF_VIS_BITS; // [R6]
          // Paired sensors are summed ahead of the even inputs
          vis_idx <= vis_idx + (mode_reg ? `SVF_VIS_STEP2
                                         : `SVF_VIS_STEP1); // [R1] [R10]
        end
      endcase
    end
    else if (state_reg == svf_pkg::svf_st_video && tick_reg)
      word_reg <= {word_reg[6:0], 1'b0};
  end

  always_comb
  begin
    unique case (state_reg)
      svf_pkg::svf_st_pre: raw_bit = alt_reg;
      svf_pkg::svf_st_sync: raw_bit = sync_sr[55];
      svf_pkg::svf_st_video: raw_bit = word_reg[7];
      default: raw_bit = 1'b0;
    endcase
  end

  // Differential encoder; the ground decoder removes phase ambiguity
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_data_reg <= 1'b0;
      ser_strobe_reg <= 1'b0;
    end
    else
    begin
      ser_strobe_reg <= tick_reg;
      if (tick_reg)
        ser_data_reg <= ser_data_reg ^ raw_bit; // [R14]
    end
  end

  assign ser_data = ser_data_reg;
  assign ser_strobe = ser_strobe_reg;
  assign line_busy = busy_reg;
  assign mode_active = mode_reg;
  assign vis_chan = vis_idx;
  assign thermal_chan = th_idx;

  a_mode_hold: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg != svf_pkg::svf_st_idle && $past(state_reg) !=
     svf_pkg::svf_st_idle) |-> $stable(mode_reg)) // [R3] [R15]
    else $error("mode changed inside a line");
  a_pre_length: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == svf_pkg::svf_st_pre ##1 state_reg ==
     svf_pkg::svf_st_sync) |-> $past(cnt_reg) == pre_last) // [R4]
    else $error("preamble length wrong");
  a_pre_first: assert property (@(posedge clk) disable iff (!nrst)
    (tick_reg && state_reg == svf_pkg::svf_st_pre && cnt_reg == 17'h0)
    |-> raw_bit) // [R4]
    else $error("preamble does not start with one");
  a_sync_length: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == svf_pkg::svf_st_sync ##1 state_reg ==
     svf_pkg::svf_st_video) |-> $past(cnt_reg) == `SVF_SYNC_LAST) // [R5]
    else $error("sync word not 56 bits");
  a_id_insert: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == svf_pkg::svf_st_idle ##1 state_reg ==
     svf_pkg::svf_st_pre) |-> sync_sr[11:0] == $past(in_filt[11:0])) // [R2]
    else $error("line ID not loaded");
  a_diff_enc: assert property (@(posedge clk) disable iff (!nrst)
    ser_strobe_reg |-> ser_data_reg == ($past(ser_data_reg) ^
    $past(raw_bit))) // [R14]
    else $error("differential encoding wrong");
  a_skip_words: assert property (@(posedge clk) disable iff (!nrst)
    (mode_reg && state_reg == svf_pkg::svf_st_video) |->
    !(pos_reg >= `SVF_POS_SKIP_A && pos_reg <= `SVF_POS_SKIP_B)) // [R7]
    else $error("deleted word sent in mode two");
  a_word_kind: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == svf_pkg::svf_st_video |-> kind_reg == word_kind(pos_reg)
    && len_reg == ((kind_reg == svf_pkg::svf_kind_th) ? `SVF_TH_BITS
    : `SVF_VIS_BITS)) // [R6] [R13]
    else $error("word kind or width wrong");
  a_tick_gap: assert property (@(posedge clk) disable iff (!nrst)
    tick_reg |=> !tick_reg ##1 !tick_reg ##1 !tick_reg) // [R12]
    else $error("bit rate too high");
  c_mode1_line: cover property (@(posedge clk) disable iff (!nrst)
    !mode_reg && state_reg == svf_pkg::svf_st_video ##1
    state_reg == svf_pkg::svf_st_idle);
  c_mode2_line: cover property (@(posedge clk) disable iff (!nrst)
    mode_reg && state_reg == svf_pkg::svf_st_video ##1
    state_reg == svf_pkg::svf_st_idle);
  c_mode_pending: cover property (@(posedge clk) disable iff (!nrst)
    busy_reg && in_filt[13] != mode_reg);
endmodule : svf_mux
`default_nettype wire

// ---- sim/svf_rx.sv ----
// Partner model: ground-side receiver of the serial video stream.
// Assumes one strobe per bit and a settled ser_data in the strobe cycle.
`timescale 1ns/100ps
`default_nettype none
module svf_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial stream from the multiplexer
  input wire logic ser_data,
  input wire logic ser_strobe
);
  logic bits[$];
  logic prev_reg;
  int gap_reg;
  int gap_min;
  int gap_max;
  bit seen;
  task automatic clear();
    bits.delete();
    gap_min = 1000;
    gap_max = 0;
    seen = 1'b0;
  endtask : clear
  // Decode against the level held before each bit
  // One lane only; the two-lane split adds nothing to checking
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_reg <= 1'b0;
      gap_reg <= 0;
    end
    else
    begin
      gap_reg <= gap_reg + 1;
      if (ser_strobe)
      begin
        bits.push_back(ser_data ^ prev_reg);
        prev_reg <= ser_data;
        gap_reg <= 1;
        if (seen && gap_reg < gap_min)
          gap_min = gap_reg;
        if (seen && gap_reg > gap_max)
          gap_max = gap_reg;
        seen = 1'b1;
      end
    end
  end
endmodule : svf_rx
`default_nettype wire

// ---- sim/tb_scan_video_frame_multiplexer.sv ----
// Testbench for the scan video frame multiplexer.
// Assumes a short preamble and one frame per line to keep runs brief.
`include "svf_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  tests_run++; \
  if ((g) !== (e)) \
  begin \
    $display("FAIL %s exp %0h got %0h", nm, e, g); \
    miscompares++; \
  end
module tb_scan_video_frame_multiplexer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mode_cmd = 1'b0;
  logic line_start = 1'b0;
  logic [11:0] line_id = 12'h000;
  logic [47:0] vis_code = 48'h0;
  logic [15:0] thermal_code = 16'h0;
  logic [2:0] vis_chan;
  logic thermal_chan;
  logic ser_data;
  logic ser_strobe;
  logic line_busy;
  logic mode_active;
  int miscompares = 0;
  int tests_run = 0;
  logic exp_q[$];
  svf_mux #(.PREAMBLE_US(1), .FRAMES_PER_LINE(1)) u_dut (
    .clk(clk), .nrst(nrst), .mode_cmd(mode_cmd), .line_start(line_start),
    .line_id(line_id), .vis_code(vis_code), .thermal_code(thermal_code),
    .vis_chan(vis_chan), .thermal_chan(thermal_chan), .ser_data(ser_data),
    .ser_strobe(ser_strobe), .line_busy(line_busy),
    .mode_active(mode_active));
  svf_rx u_rx (.clk(clk), .nrst(nrst), .ser_data(ser_data),
    .ser_strobe(ser_strobe));
  always #2 clk = ~clk;
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Expected raw bits of one line, before differential coding
  task automatic gen(input logic m);
    int vi;
    int ti;
    int wl;
    int vc;
    logic [7:0] w;
    logic [43:0] sy;
    exp_q.delete();
    vi = 0;
    ti = 0;
    sy = `SVF_LINE_SYNC;
    // Bench runs a 1 us preamble: one bit per Mb/s of rate
    for (int i = 0;
         i < (m ? `SVF_RATE2_KBPS : `SVF_RATE1_KBPS) / `SVF_US_PER_MS;
         i++)
      exp_q.push_back(~i[0]);
    for (int i = 43; i >= 0; i--)
      exp_q.push_back(sy[i]);
    for (int i = 11; i >= 0; i--)
      exp_q.push_back(line_id[i]);
    for (int p = 1; p <= 36; p++)
    begin
      if (m && p >= 6 && p <= 9)
        continue;
      wl = 6;
      if (p == 1 || p == 19)
        w = (p == 1) ? {2'b00, `SVF_BARKER} : {2'b00, ~`SVF_BARKER};
      else if (p == 2 || p == 11 || p == 20 || p == 29)
      begin
        w = thermal_code[8 * ti +: 8];
        ti = 1 - ti;
        wl = 8;
      end
      else
      begin
        vc = m ? (vi % 4) * 2 : vi % 8;
        w = {2'b00, vis_code[6 * vc +: 6]};
        vi++;
      end
      for (int b = wl - 1; b >= 0; b--)
        exp_q.push_back(w[b]);
    end
  endtask : gen
  task automatic run_line(input logic m, input logic glitch, input int k);
    int n;
    int lo;
    @(posedge clk);
    mode_cmd <= m;
    line_id <= (k == 0) ? 12'hfff : 12'($urandom());
    vis_code <= (k == 0) ? 48'hffff_ffff_ffff : {$urandom(), 16'($urandom())};
    thermal_code <= (k == 1) ? 16'h0 : 16'($urandom());
    repeat (10) @(posedge clk);
    u_rx.clear();
    line_start <= 1'b1;
    n = 0;
    while (line_busy !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("busy rise", 1'b1, line_busy)
    @(posedge clk);
    `CHK("mode", m, mode_active)
    gen(m);
    repeat (8) @(posedge clk);
    line_start <= 1'b0;
    if (glitch)
    begin
      repeat (40) @(posedge clk);
      mode_cmd <= ~m;
      line_start <= 1'b1;
      repeat (12) @(posedge clk);
      line_start <= 1'b0;
    end
    n = 0;
    while (line_busy !== 1'b0 && n < 12000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
    `CHK("mode held", m, mode_active)
    `CHK("vis chan rewound", 3'h0, vis_chan)
    `CHK("thermal chan rewound", 1'b0, thermal_chan)
    `CHK("bit count", exp_q.size(), u_rx.bits.size())
    for (int i = 0; i < exp_q.size() && i < u_rx.bits.size(); i++)
    begin
      `CHK("bit", exp_q[i], u_rx.bits[i])
    end
    lo = `SVF_CLK_KHZ / (m ? `SVF_RATE2_KBPS : `SVF_RATE1_KBPS);
    `CHK("gap min", 1'b1, u_rx.gap_min >= lo)
    `CHK("gap max", 1'b1, u_rx.gap_max <= lo + 1)
  endtask : run_line
  initial
  begin
    void'($urandom(36555));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("idle strobe", 1'b0, ser_strobe)
    `CHK("idle busy", 1'b0, line_busy)
    `CHK("idle vis chan", 3'h0, vis_chan)
    `CHK("idle thermal chan", 1'b0, thermal_chan)
    // Glitches restart the pin mid-line: mode must wait for the next line and the start is ignored
    for (int k = 0; k < 6; k++)
      run_line(k[0], k >= 2, k);
    close_out();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule : tb_scan_video_frame_multiplexer
`default_nettype wire
